// file: inc/dqc_pkg.sv
// Shared constants and carrier types for the acquisition control block.
`default_nettype none
package dqc_pkg;
  // ***************************************************
  // Register word offsets (byte addresses).
  // ***************************************************
  localparam logic [5:0] OFS_COUNTER_ZERO = 6'h00;
  localparam logic [5:0] OFS_COUNTER_ONE = 6'h04;
  localparam logic [5:0] OFS_COUNTER_TWO = 6'h08;
  localparam logic [5:0] OFS_COUNTER_MODE_CONTROL = 6'h0c;
  localparam logic [5:0] OFS_CONVERSION_RESULT_OUT_CH1 = 6'h10;
  localparam logic [5:0] OFS_ANALOG_OUT_CH2 = 6'h14;
  localparam logic [5:0] OFS_CONVERSION_STATUS_CONTROL = 6'h18;
  localparam logic [5:0] OFS_DIGITAL_PORT = 6'h1c;
  localparam logic [5:0] OFS_CONVERSION_SOFT_TRIGGER = 6'h20;
  // ***************************************************
  // Control word fields.
  // ***************************************************
  localparam int CTL_BUSMASTER_BIT = 0;
  localparam int CTL_IRQ_BIT = 1;
  localparam int CTL_PACER_BIT = 2;
  localparam int CTL_SOURCE_BIT = 3;
  localparam int CTL_SCAN_BIT = 4;
  localparam int CTL_CHAN_LSB = 5;
  localparam int CTL_GAIN_LSB = 9;
  localparam int CTL_WIDTH = 13;
  localparam logic [12:0] CTL_RESET = 13'h0000;
  // ***************************************************
  // Status and data word fields.
  // ***************************************************
  localparam int STS_READY_BIT = 0;
  localparam int STS_OVERRUN_BIT = 1;
  localparam int RES_TAG_LSB = 0;
  localparam int RES_DATA_LSB = 4;
  localparam int CODE_W = 12;
  localparam int CHAN_W = 4;
  localparam int GAIN_W = 4;
  localparam int DIO_W = 16;
  localparam logic [11:0] DAC_RESET = 12'h000;
  // ***************************************************
  // Carrier types.
  // ***************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [31:0] wdata;
  } dqc_req_t;
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } dqc_rsp_t;
  typedef struct packed {
    logic start;
    logic [3:0] chan;
    logic [3:0] gain;
  } dqc_adc_t;
  typedef struct packed {
    logic stb;
    logic write;
    logic [1:0] index;
    logic [31:0] wdata;
  } dqc_cnt_t;
endpackage
`default_nettype wire

// file: rtl/dqc_trig_sel.sv
// Trigger source selection with external trigger pin synchroniser.
`default_nettype none
module dqc_trig_sel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_trig_pin,
  input wire logic pacer_tick,
  input wire logic soft_trig,
  input wire logic source_ext,
  input wire logic pacer_sel,
  output logic trig
);
  logic sync1_q;
  logic sync2_q;
  logic last_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= ext_trig_pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  // External source masks every internal source; pacer only counts when internal.
  always_comb begin
    if (source_ext) begin
      trig = sync2_q & ~last_q;
    end else if (pacer_sel) begin
      trig = pacer_tick;
    end else begin
      trig = soft_trig;
    end
  end
endmodule
`default_nettype wire

// file: rtl/dqc_chan_scan.sv
// Input multiplexer channel stepper with downward auto-scan.
`default_nettype none
module dqc_chan_scan (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [dqc_pkg::CHAN_W-1:0] top_chan,
  input wire logic auto_scan,
  input wire logic advance,
  output logic [dqc_pkg::CHAN_W-1:0] cur_chan
);
  import dqc_pkg::*;
  logic [CHAN_W-1:0] chan_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan_q <= '0;
    end else if (load) begin
      chan_q <= top_chan;
    end else if (advance && auto_scan) begin
      chan_q <= (chan_q == '0) ? top_chan : chan_q - 1'b1;
    end else if (advance) begin
      chan_q <= top_chan;
    end
  end

  assign cur_chan = chan_q;
endmodule
`default_nettype wire

// file: rtl/dqc_core.sv
// Register window and conversion control of the acquisition card.
`default_nettype none
module dqc_core (
  input wire logic clk,
  input wire logic resetn,
  input wire dqc_pkg::dqc_req_t req,
  output dqc_pkg::dqc_rsp_t rsp,
  output dqc_pkg::dqc_cnt_t cnt_acc,
  input wire logic [31:0] cnt_rdata,
  input wire logic pacer_tick,
  input wire logic ext_trig_pin,
  output dqc_pkg::dqc_adc_t adc_ctl,
  input wire logic adc_done,
  input wire logic [dqc_pkg::CODE_W-1:0] adc_data,
  output logic [dqc_pkg::CODE_W-1:0] dac_ch1,
  output logic [dqc_pkg::CODE_W-1:0] dac_ch2,
  input wire logic [dqc_pkg::DIO_W-1:0] din_pins,
  output logic [dqc_pkg::DIO_W-1:0] dout_pins,
  output logic irq_req,
  output logic dma_req,
  input wire logic dma_ack,
  output logic [3:0] gain_code
);
  import dqc_pkg::*;

  typedef enum logic {ST_IDLE, ST_CONV} dqc_state_t;

  // ***************************************************
  // Register access decode.
  // ***************************************************
  logic wr;
  logic rd;
  logic wr_result;
  logic wr_ch2;
  logic wr_ctl;
  logic wr_dio;
  logic wr_trig;
  logic rd_result;
  logic rd_status;
  logic hit_cnt;

  assign wr = req.valid & req.write;
  assign rd = req.valid & ~req.write;
  assign wr_result = wr && req.addr == OFS_CONVERSION_RESULT_OUT_CH1;
  assign wr_ch2 = wr && req.addr == OFS_ANALOG_OUT_CH2;
  assign wr_ctl = wr && req.addr == OFS_CONVERSION_STATUS_CONTROL;
  assign wr_dio = wr && req.addr == OFS_DIGITAL_PORT;
  assign wr_trig = wr && req.addr == OFS_CONVERSION_SOFT_TRIGGER;
  assign rd_result = rd && req.addr == OFS_CONVERSION_RESULT_OUT_CH1;
  assign rd_status = rd && req.addr == OFS_CONVERSION_STATUS_CONTROL;
  assign hit_cnt = req.addr[5:4] == 2'b00 && req.addr[1:0] == 2'b00;

  // Counter accesses, except reads of the mode control word, are passed straight to the counter/timer block.
  always_comb begin
    cnt_acc.stb = req.valid & hit_cnt & ~(~req.write & req.addr == OFS_COUNTER_MODE_CONTROL);
    cnt_acc.write = req.write;
    cnt_acc.index = req.addr[3:2];
    cnt_acc.wdata = req.wdata;
  end

  // ***************************************************
  // Control register.
  // ***************************************************
  logic [CTL_WIDTH-1:0] ctl_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= req.wdata[CTL_WIDTH-1:0];
    end
  end

  logic busmaster_transfer_enable;
  logic irq_transfer_enable;
  logic pacer_or_soft_select;
  logic trigger_source_select;
  logic auto_scan;
  logic [CHAN_W-1:0] input_channel_select;

  assign busmaster_transfer_enable = ctl_q[CTL_BUSMASTER_BIT];
  assign irq_transfer_enable = ctl_q[CTL_IRQ_BIT];
  assign pacer_or_soft_select = ctl_q[CTL_PACER_BIT];
  assign trigger_source_select = ctl_q[CTL_SOURCE_BIT];
  assign auto_scan = ctl_q[CTL_SCAN_BIT];
  assign input_channel_select = ctl_q[CTL_CHAN_LSB +: CHAN_W];
  assign gain_code = ctl_q[CTL_GAIN_LSB +: GAIN_W];

  // ***************************************************
  // Analog outputs and digital port.
  // ***************************************************
  logic [CODE_W-1:0] dac1_q;
  logic [CODE_W-1:0] dac2_q;
  logic [DIO_W-1:0] dout_q;
  logic [DIO_W-1:0] din_s1_q;
  logic [DIO_W-1:0] din_s2_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac1_q <= DAC_RESET;
      dac2_q <= DAC_RESET;
    end else begin
      if (wr_result) begin
        dac1_q <= req.wdata[CODE_W-1:0];
      end
      if (wr_ch2) begin
        dac2_q <= req.wdata[CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_q <= '0;
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= din_pins;
      din_s2_q <= din_s1_q;
      if (wr_dio) begin
        dout_q <= req.wdata[DIO_W-1:0];
      end
    end
  end

  assign dac_ch1 = dac1_q;
  assign dac_ch2 = dac2_q;
  assign dout_pins = dout_q;

  // ***************************************************
  // Trigger and channel selection.
  // ***************************************************
  logic trig;
  logic [CHAN_W-1:0] cur_chan;
  dqc_state_t state_q;
  logic start;

  dqc_trig_sel u_trig (
    .clk(clk),
    .resetn(resetn),
    .ext_trig_pin(ext_trig_pin),
    .pacer_tick(pacer_tick),
    .soft_trig(wr_trig),
    .source_ext(trigger_source_select),
    .pacer_sel(pacer_or_soft_select),
    .trig(trig)
  );

  assign start = trig && state_q == ST_IDLE && !wr_ctl;

  // A control write loads its new channel at once; otherwise each start steps down in auto-scan, or returns to the programmed channel.
  logic [CHAN_W-1:0] scan_top;

  assign scan_top = wr_ctl ? req.wdata[CTL_CHAN_LSB +: CHAN_W] : input_channel_select;

  dqc_chan_scan u_scan (
    .clk(clk),
    .resetn(resetn),
    .load(wr_ctl),
    .top_chan(scan_top),
    .auto_scan(auto_scan),
    .advance(start),
    .cur_chan(cur_chan)
  );

  // ***************************************************
  // Conversion sequence.
  // ***************************************************
  logic ready_q;
  logic pending_q;
  logic overrun_q;
  logic [CHAN_W-1:0] tag_q;
  logic [CHAN_W-1:0] conv_tag_q;
  logic [CODE_W-1:0] result_q;
  logic complete;

  assign complete = state_q == ST_CONV && adc_done;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (adc_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // The ready flag drops on start and returns on completion.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else if (start) begin
      ready_q <= 1'b0;
    end else if (complete) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_tag_q <= '0;
      tag_q <= '0;
      result_q <= '0;
    end else begin
      if (start) begin
        conv_tag_q <= cur_chan;
      end
      if (complete) begin
        result_q <= adc_data;
        tag_q <= conv_tag_q;
      end
    end
  end

  // A new result sets pending; a completion wins over a same-cycle take.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (complete) begin
      pending_q <= 1'b1;
    end else if (rd_result || dma_ack) begin
      pending_q <= 1'b0;
    end
  end

  // Overrun is cleared by a status read unless a new overrun hits that cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
    end else if (complete && pending_q && busmaster_transfer_enable && !(rd_result || dma_ack)) begin
      overrun_q <= 1'b1;
    end else if (rd_status) begin
      overrun_q <= 1'b0;
    end
  end

  assign dma_req = busmaster_transfer_enable & pending_q;
  assign irq_req = irq_transfer_enable & ~busmaster_transfer_enable & pending_q;

  always_comb begin
    adc_ctl.start = start;
    adc_ctl.chan = cur_chan;
    adc_ctl.gain = gain_code;
  end

  // ***************************************************
  // Read data path.
  // ***************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp.valid <= 1'b0;
      rsp.rdata <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.rdata <= '0;
      if (rd) begin
        case (req.addr)
          OFS_COUNTER_ZERO, OFS_COUNTER_ONE, OFS_COUNTER_TWO: begin
            rsp.rdata <= cnt_rdata;
          end
          OFS_CONVERSION_RESULT_OUT_CH1: begin
            rsp.rdata <= {16'h0000, result_q, tag_q};
          end
          OFS_CONVERSION_STATUS_CONTROL: begin
            rsp.rdata <= {30'h00000000, overrun_q, ready_q};
          end
          OFS_DIGITAL_PORT: begin
            rsp.rdata <= {16'h0000, din_s2_q};
          end
          default: begin
            rsp.rdata <= '0;
          end
        endcase
      end
    end
  end

  // ***************************************************
  // Checks.
  // ***************************************************
  ready_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    start |=> !ready_q) else $error("ready flag did not drop on start");

  ready_rise_a: assert property (@(posedge clk) disable iff (!resetn)
    complete |=> ready_q && state_q == ST_IDLE) else $error("ready flag did not return on completion");

  result_word_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_result |=> rsp.rdata == {16'h0000, $past(result_q), $past(tag_q)}) else $error("data word wrong");

  dac_load_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_ch2 |=> dac_ch2 == $past(req.wdata[11:0])) else $error("channel two output not loaded");

  mux_switch_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_ctl |=> adc_ctl.chan == $past(req.wdata[8:5])) else $error("multiplexer did not switch");

  ext_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    trigger_source_select && adc_ctl.start |-> $past(ext_trig_pin, 2) && !$past(ext_trig_pin, 3))
    else $error("internal trigger started conversion in external mode");

  soft_start_a: assert property (@(posedge clk) disable iff (!resetn)
    !trigger_source_select && !pacer_or_soft_select && wr_trig && state_q == ST_IDLE ##1 1'b1
    |-> state_q == ST_CONV) else $error("soft trigger did not start conversion");

  scan_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    start && auto_scan && cur_chan == 4'h0 && !wr_ctl |=> cur_chan == input_channel_select)
    else $error("auto-scan did not wrap");

  xfer_excl_a: assert property (@(posedge clk) disable iff (!resetn)
    !(irq_req && dma_req)) else $error("both transfer requests raised");

  overrun_set_a: assert property (@(posedge clk) disable iff (!resetn)
    complete && pending_q && busmaster_transfer_enable && !rd_result && !dma_ack |=> overrun_q)
    else $error("overrun not flagged");
endmodule
`default_nettype wire

// file: verif/dqc_host_model.sv
// Host-side model that issues single-word register accesses to the block.
`default_nettype none
module dqc_host_model (
  input wire logic clk,
  output dqc_pkg::dqc_req_t req,
  input wire dqc_pkg::dqc_rsp_t rsp,
  output logic timed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dqc_pkg::*;
  initial req = '0;
  initial timed_out = 1'b0;
  // ***************************************************
  // One whole 32-bit word per access, never byte lanes.
  // ***************************************************
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    r = '0;
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    // Idle request fields carry scrambled values so stale data is never trusted.
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.valid !== 1'b1 && n < 4);
    if (rsp.valid !== 1'b1) timed_out = 1'b1;
    r = rsp.rdata;
  endtask
endmodule
`default_nettype wire

// file: verif/test_dqc_core.sv
// Self-checking bench for the acquisition register window and conversion control.
`default_nettype none
module test_dqc_core;
  timeunit 1ns;
  timeprecision 1ps;
  import dqc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  dqc_req_t req;
  dqc_rsp_t rsp;
  dqc_adc_t adc_ctl;
  dqc_cnt_t cnt_acc;
  dqc_cnt_t cnt_seen = '0;
  logic pacer_tick = 1'b0;
  logic ext_trig_pin = 1'b0;
  logic adc_done = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [11:0] code_next = 12'h000;
  logic dma_ack = 1'b0;
  logic [11:0] dac_ch1;
  logic [11:0] dac_ch2;
  logic [15:0] dout_pins;
  logic irq_req;
  logic dma_req;
  logic timed_out;
  logic [3:0] gain_code;
  logic [31:0] rd;
  int conv_cnt = 0;
  int n_starts = 0;
  int n_errors = 0;
  int cmp_count = 0;

  initial forever #2.5 clk = ~clk;

  dqc_host_model dqc_host_model_i (.clk(clk), .req(req), .rsp(rsp), .timed_out(timed_out));

  dqc_core dqc_core_i (
    .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .cnt_acc(cnt_acc), .cnt_rdata(32'h1357_9bdf),
    .pacer_tick(pacer_tick), .ext_trig_pin(ext_trig_pin), .adc_ctl(adc_ctl), .adc_done(adc_done),
    .adc_data(adc_data), .dac_ch1(dac_ch1), .dac_ch2(dac_ch2), .din_pins(16'h0f1e),
    .dout_pins(dout_pins), .irq_req(irq_req), .dma_req(dma_req), .dma_ack(dma_ack), .gain_code(gain_code)
  );

  // Counter block model: remembers the last strobed counter access.
  always @(posedge clk) begin
    if (cnt_acc.stb === 1'b1) cnt_seen <= cnt_acc;
  end

  // ***************************************************
  // Converter model: ten cycles per conversion, data scrambled outside completion.
  // ***************************************************
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_ctl.start === 1'b1) n_starts <= n_starts + 1;
    if (conv_cnt > 0) begin
      conv_cnt <= conv_cnt - 1;
      if (conv_cnt == 1) begin
        adc_done <= 1'b1;
        adc_data <= code_next;
      end
    end else if (adc_ctl.start === 1'b1) begin
      conv_cnt <= 10;
    end
  end

  // ***************************************************
  // Reporting and shared helpers.
  // ***************************************************
  task automatic summarize();
    $display("comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic err(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) err(m);
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) err(m);
  endtask

  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    dqc_host_model_i.xfer(w, a, d, r);
    if (timed_out) begin
      err("no register response");
      summarize();
    end
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] mode, input logic scan, input logic [3:0] chan,
                                      input logic [3:0] gain);
    return {19'h0, gain, chan, scan, mode};
  endfunction

  // Pulses pacer (0), bus-master acknowledge (1) or external pin (2) for one cycle.
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) pacer_tick <= 1'b1;
    else if (k == 1) dma_ack <= 1'b1;
    else ext_trig_pin <= 1'b1;
    @(posedge clk);
    pacer_tick <= 1'b0;
    dma_ack <= 1'b0;
    ext_trig_pin <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (adc_done !== 1'b1 && n < 40);
    if (adc_done !== 1'b1) begin
      err("conversion never completed");
      summarize();
    end
    @(negedge clk);
    @(negedge clk);
  endtask

  task automatic conv_soft(input logic [3:0] tag);
    code_next = {~tag, tag, 4'h9};
    acc(1'b1, OFS_CONVERSION_SOFT_TRIGGER, 32'h0, rd);
    acc(1'b0, OFS_CONVERSION_STATUS_CONTROL, 32'h0, rd);
    chk_flag(rd[0], 1'b0, "ready while converting");
    wait_done();
    acc(1'b0, OFS_CONVERSION_STATUS_CONTROL, 32'h0, rd);
    chk_flag(rd[0], 1'b1, "ready after completion");
    acc(1'b0, OFS_CONVERSION_RESULT_OUT_CH1, 32'h0, rd);
    chk_word(rd, {16'h0, code_next, tag}, "result word");
  endtask

  // ***************************************************
  // Scenarios.
  // ***************************************************
  task automatic t_regs();
    chk_word({gain_code, dac_ch1, dac_ch2, adc_ctl.chan}, 32'h0, "reset values");
    chk_flag(irq_req | dma_req, 1'b0, "transfer request after reset");
    acc(1'b0, OFS_CONVERSION_STATUS_CONTROL, 32'h0, rd);
    chk_word(rd, 32'h0, "status after reset");
    acc(1'b1, OFS_CONVERSION_RESULT_OUT_CH1, 32'hffff_f5a3, rd);
    acc(1'b1, OFS_ANALOG_OUT_CH2, 32'h1234_6c9e, rd);
    chk_word({8'h0, dac_ch1, dac_ch2}, 32'h005a_3c9e, "output codes");
    acc(1'b0, OFS_ANALOG_OUT_CH2, 32'h0, rd);
    chk_word(rd, 32'h0, "write-only output read");
    acc(1'b0, 6'h24, 32'h0, rd);
    chk_word(rd, 32'h0, "unmapped read");
    acc(1'b0, OFS_COUNTER_ONE, 32'h0, rd);
    chk_word(rd, 32'h1357_9bdf, "counter read");
    chk_word({28'h0, cnt_seen.stb, cnt_seen.write, cnt_seen.index}, 32'h9, "counter read access");
    acc(1'b1, OFS_COUNTER_MODE_CONTROL, 32'h0000_00b6, rd);
    chk_word(cnt_seen.wdata, 32'h0000_00b6, "counter control data");
    acc(1'b0, OFS_COUNTER_MODE_CONTROL, 32'h0, rd);
    chk_word(rd, 32'h0, "counter control read");
    chk_word({28'h0, cnt_seen.stb, cnt_seen.write, cnt_seen.index}, 32'hf, "counter control access");
    acc(1'b1, OFS_DIGITAL_PORT, 32'h0000_3c5a, rd);
    acc(1'b0, OFS_DIGITAL_PORT, 32'h0, rd);
    chk_word({dout_pins, rd[15:0]}, 32'h3c5a_0f1e, "digital port");
  endtask

  task automatic t_ctl();
    for (int g = 0; g < 9; g++) begin
      acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'h0, 1'b0, 4'(15 - g), 4'(g)) | 32'hffffe000, rd);
      chk_word({28'h0, gain_code}, 32'(g), "gain code");
      chk_word({24'h0, adc_ctl.gain, adc_ctl.chan}, {24'h0, 4'(g), 4'(15 - g)}, "converter select");
    end
  endtask

  task automatic t_scan();
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'h0, 1'b0, 4'h3, 4'h0), rd);
    conv_soft(4'h3);
    conv_soft(4'h3);
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'h0, 1'b1, 4'h2, 4'h0), rd);
    for (int i = 0; i < 4; i++) conv_soft(4'(2 - i % 3));
  endtask

  task automatic t_dma();
    int s;
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'b0101, 1'b0, 4'h0, 4'h0), rd);
    s = n_starts;
    acc(1'b1, OFS_CONVERSION_SOFT_TRIGGER, 32'h0, rd);
    chk_word(32'(n_starts), 32'(s), "soft trigger in pacer mode");
    code_next = 12'h7e1;
    pulse(0);
    wait_done();
    chk_word({30'h0, dma_req, irq_req}, 32'h2, "bus-master request");
    pulse(0);
    wait_done();
    acc(1'b0, OFS_CONVERSION_STATUS_CONTROL, 32'h0, rd);
    chk_word(rd, 32'h3, "overrun shown");
    acc(1'b0, OFS_CONVERSION_STATUS_CONTROL, 32'h0, rd);
    chk_word(rd, 32'h1, "overrun cleared");
    pulse(1);
    @(negedge clk);
    chk_flag(dma_req, 1'b0, "request after acknowledge");
  endtask

  task automatic t_irq();
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'b0110, 1'b0, 4'h1, 4'h0), rd);
    pulse(0);
    wait_done();
    chk_word({30'h0, dma_req, irq_req}, 32'h1, "interrupt request");
    acc(1'b0, OFS_CONVERSION_RESULT_OUT_CH1, 32'h0, rd);
    chk_flag(irq_req, 1'b0, "interrupt request after read");
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'b0111, 1'b0, 4'h1, 4'h0), rd);
    pulse(0);
    wait_done();
    chk_word({30'h0, dma_req, irq_req}, 32'h2, "both transfers enabled");
    pulse(1);
  endtask

  task automatic t_ext();
    int s;
    acc(1'b1, OFS_CONVERSION_STATUS_CONTROL, ctl(4'b1000, 1'b0, 4'h0, 4'h0), rd);
    s = n_starts;
    acc(1'b1, OFS_CONVERSION_SOFT_TRIGGER, 32'h0, rd);
    pulse(0);
    repeat (12) @(negedge clk);
    chk_word(32'(n_starts), 32'(s), "internal trigger while external");
    pulse(2);
    wait_done();
    chk_word(32'(n_starts), 32'(s + 1), "external trigger start");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_regs();
    t_ctl();
    t_scan();
    t_dma();
    t_irq();
    t_ext();
    summarize();
  end

  initial begin
    #100us;
    err("run did not finish in time");
    summarize();
  end
endmodule
`default_nettype wire
